// File: hw/modbus_point_mapper.sv
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "modbus_point_mapper_params.svh"

// Functional notes
// RL1: Up to 256 point-map entries, each redirecting one holding register internally.
// RL2: Up to 16 bulk maps, each a window over an instance array.
// RL3: Point-map entries serve both reads and writes, gated by access mode.
// RL4: With factory lock active, writes into the safety range are refused.
// RL5: Unit id selects space; ids 0 and 3-255 expose no points.
// RL6: Unit id 1 reaches fixed data models starting at register 40000.
// RL7: Unit id 2 reaches configurable point space starting at register 0.
// RL8: Only holding-register function codes are served; clients must use them.
// RL9: Region 0, addresses 0x0000-0x03FF, holds individually mapped points.
// RL10: Bulk regions 1-16 are read-only 0x780-wide windows from 0x0400 to 0x7BFF.
// RL11: Entry access mode 0 is read-only, 1 is read/write.
// RL12: Each entry holds the internal target address of its point.
// RL13: Each bulk map holds a base pointer to its first instance.
// RL14: Each bulk map holds a presence pointer deciding instance validity.
// RL15: Fixed models lie back to back from base 40000.
// RL16: Identification model always comes first in fixed space.
// RL17: Terminating end model comes last; clients stop there.
// RL18: Middle models start with identifier and length for walking.
// RL19: Writes to read-only entries or bulk windows get an exception, no change.
// RL20: Bulk offset k returns instance k from the map's base pointer.
module modbus_point_mapper
    import point_mapper_pkg::*;
#(
    parameter int          MAP_ENTRIES = 256,
    parameter int          BULK_MAPS   = 16,
    parameter logic [15:0] FIXED_LEN   = 16'h0400
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite register slave
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Modbus request from the TCP front end
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [7:0]  req_unit,
    input  wire logic [7:0]  req_func,
    input  wire logic [15:0] req_addr,
    input  wire logic [15:0] req_wdata,
    // Modbus answer, exception code zero on success
    output logic             rsp_valid,
    output logic [15:0]      rsp_data,
    output logic [7:0]       rsp_exc,
    // Internal register fabric
    output logic             ir_req,
    output logic             ir_we,
    output logic             ir_fixed,
    output logic [15:0]      ir_addr,
    output logic [15:0]      ir_wdata,
    input  wire logic        ir_ack,
    input  wire logic [15:0] ir_rdata,
    // Factory-configuration lock pin
    input  wire logic        factory_lock
);

    if (MAP_ENTRIES < 1 || MAP_ENTRIES > 256) begin : g_chk_map
        $error("MAP_ENTRIES must be 1..256");
    end
    if (BULK_MAPS < 1 || BULK_MAPS > 16) begin : g_chk_bulk
        $error("BULK_MAPS must be 1..16");
    end
    if ({1'b0, FIXED_LEN} + {1'b0, `MPM_FIXED_BASE} > 17'h10000) begin : g_chk_fix
        $error("FIXED_LEN overruns the register space");
    end

    // ****************************************************************
    // Configuration store
    // ****************************************************************
    logic [15:0]  map_target_q [MAP_ENTRIES];
    logic         map_mode_q   [MAP_ENTRIES];
    logic [15:0]  bulk_base_pointer_q     [BULK_MAPS];
    logic [15:0]  bulk_presence_pointer_q [BULK_MAPS];
    logic [15:0]  safe_lo_q;
    logic [15:0]  safe_hi_q;
    logic         lock_meta_q;
    logic         lock_q;

    mapper_state_e state_q;
    logic [7:0]   lat_unit_q;
    logic [7:0]   lat_func_q;
    logic [15:0]  lat_addr_q;
    logic [15:0]  lat_wdata_q;
    logic [3:0]   bulk_idx_q;
    logic [15:0]  bulk_k_q;

    // Lock pin is asynchronous to aclk
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_meta_q <= 1'b0;
            lock_q      <= 1'b0;
        end else begin
            lock_meta_q <= factory_lock;
            lock_q      <= lock_meta_q;
        end
    end

    function automatic logic [32:0] cfg_read(input logic [11:0] a);
        logic [32:0] r;
        r = '0;
        if (a[11:10] == 2'b00) begin
            if ({1'b0, a[9:2]} < 9'(MAP_ENTRIES)) begin
                r = {1'b1, 15'h0000, map_mode_q[a[9:2]], map_target_q[a[9:2]]};
            end
        end else if ({a[11:6], 6'h00} == `MPM_OFS_BULK_BASE) begin
            if ({1'b0, a[5:2]} < 5'(BULK_MAPS)) begin
                r = {1'b1, 16'h0000, bulk_base_pointer_q[a[5:2]]};
            end
        end else if ({a[11:6], 6'h00} == `MPM_OFS_BULK_PRES) begin
            if ({1'b0, a[5:2]} < 5'(BULK_MAPS)) begin
                r = {1'b1, 16'h0000, bulk_presence_pointer_q[a[5:2]]};
            end
        end else if ({a[11:2], 2'b00} == `MPM_OFS_SAFE_LO) begin
            r = {1'b1, 16'h0000, safe_lo_q};
        end else if ({a[11:2], 2'b00} == `MPM_OFS_SAFE_HI) begin
            r = {1'b1, 16'h0000, safe_hi_q};
        end else if ({a[11:2], 2'b00} == `MPM_OFS_STATUS) begin
            r = {1'b1, 16'h0000, rsp_exc, 6'h00, (state_q != ST_IDLE), lock_q};
        end
        return r;
    endfunction

    // ****************************************************************
    // AXI4-Lite write channel
    // ****************************************************************
    logic         aw_got_q;
    logic         w_got_q;
    logic [11:0]  aw_addr_q;
    logic [31:0]  w_data_q;
    logic [3:0]   w_strb_q;
    logic [32:0]  wr_old;
    logic [31:0]  wr_val;
    logic         wr_fire;
    logic         wr_ro;

    always_comb begin
        wr_old  = cfg_read(aw_addr_q);
        wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
        wr_ro   = ({aw_addr_q[11:2], 2'b00} == `MPM_OFS_STATUS);
        for (int b = 0; b < 4; b++) begin
            wr_val[b*8 +: 8] = w_strb_q[b] ? w_data_q[b*8 +: 8] : wr_old[b*8 +: 8];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_got_q      <= 1'b0;
            w_got_q       <= 1'b0;
            aw_addr_q     <= 12'h000;
            w_data_q      <= 32'h00000000;
            w_strb_q      <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `MPM_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q     <= s_axi_awaddr;
                aw_got_q      <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                w_got_q      <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_old[32] && !wr_ro) ? `MPM_RESP_OKAY : `MPM_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < MAP_ENTRIES; i++) begin
                map_target_q[i] <= 16'h0000;
                map_mode_q[i]   <= `MPM_MODE_RO;
            end
            for (int i = 0; i < BULK_MAPS; i++) begin
                bulk_base_pointer_q[i]     <= 16'h0000;
                bulk_presence_pointer_q[i] <= 16'h0000;
            end
            safe_lo_q <= `MPM_SAFE_LO_RST;
            safe_hi_q <= `MPM_SAFE_HI_RST;
        end else if (wr_fire && wr_old[32]) begin
            // RL11 RL12 mode and target store
            if (aw_addr_q[11:10] == 2'b00) begin
                map_target_q[aw_addr_q[9:2]] <= wr_val[15:0];
                map_mode_q[aw_addr_q[9:2]]   <= wr_val[`MPM_MAP_MODE_BIT];
            // RL13 bulk base store
            end else if ({aw_addr_q[11:6], 6'h00} == `MPM_OFS_BULK_BASE) begin
                bulk_base_pointer_q[aw_addr_q[5:2]] <= wr_val[15:0];
            // RL14 presence pointer store
            end else if ({aw_addr_q[11:6], 6'h00} == `MPM_OFS_BULK_PRES) begin
                bulk_presence_pointer_q[aw_addr_q[5:2]] <= wr_val[15:0];
            end else if ({aw_addr_q[11:2], 2'b00} == `MPM_OFS_SAFE_LO) begin
                safe_lo_q <= wr_val[15:0];
            end else if ({aw_addr_q[11:2], 2'b00} == `MPM_OFS_SAFE_HI) begin
                safe_hi_q <= wr_val[15:0];
            end
        end
    end

    // ****************************************************************
    // AXI4-Lite read channel
    // ****************************************************************
    logic [32:0] rd_val;

    always_comb rd_val = cfg_read(s_axi_araddr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `MPM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_val[31:0];
            s_axi_rresp   <= rd_val[32] ? `MPM_RESP_OKAY : `MPM_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ****************************************************************
    // Request decode
    // ****************************************************************
    logic        is_write;
    logic        func_ok;
    logic        in_map;
    logic        in_fixed;
    logic        in_bulk;
    logic        bulk_ok;
    logic [7:0]  map_idx;
    logic [15:0] bulk_off;
    logic [15:0] bulk_reg;
    logic [15:0] bulk_k;
    logic [15:0] tgt;
    logic        tgt_safe;
    logic [7:0]  dec_exc;
    logic        dec_go;
    logic        dec_pres;

    always_comb begin
        is_write = (lat_func_q == `MPM_FC_WRITE_HOLD);
        // RL8 holding codes only
        func_ok  = is_write || (lat_func_q == `MPM_FC_READ_HOLD);
        map_idx  = lat_addr_q[7:0];
        // RL9 region zero bounds
        in_map   = (lat_addr_q <= `MPM_REGION0_END) && ({1'b0, lat_addr_q} < 17'(MAP_ENTRIES));
        // RL15 contiguous fixed space
        in_fixed = (lat_addr_q >= `MPM_FIXED_BASE)
                   && ({1'b0, lat_addr_q} < {1'b0, `MPM_FIXED_BASE} + {1'b0, FIXED_LEN});
        // RL10 equal bulk windows
        in_bulk  = (lat_addr_q >= `MPM_BULK_START) && (lat_addr_q <= `MPM_BULK_END);
        bulk_off = lat_addr_q - `MPM_BULK_START;
        bulk_reg = bulk_off / `MPM_BULK_SPAN;
        bulk_k   = bulk_off % `MPM_BULK_SPAN;
        // RL2 bulk map count
        bulk_ok  = bulk_reg < 16'(BULK_MAPS);
        tgt      = map_target_q[map_idx];
        tgt_safe = (tgt >= safe_lo_q) && (tgt <= safe_hi_q);
        dec_exc  = `MPM_EXC_NONE;
        dec_go   = 1'b0;
        dec_pres = 1'b0;
        if (!func_ok) begin
            dec_exc = `MPM_EXC_FUNC;
        // RL6 fixed model space
        end else if (lat_unit_q == `MPM_UNIT_FIXED) begin
            dec_go  = in_fixed;
            dec_exc = in_fixed ? `MPM_EXC_NONE : `MPM_EXC_ADDR;
        // RL7 configurable space
        end else if (lat_unit_q == `MPM_UNIT_CONFIG) begin
            if (in_map) begin
                // RL19 read-only entry
                if (is_write && map_mode_q[map_idx] == `MPM_MODE_RO) begin
                    dec_exc = `MPM_EXC_VALUE;
                // RL4 factory lock guard
                end else if (is_write && lock_q && tgt_safe) begin
                    dec_exc = `MPM_EXC_VALUE;
                end else begin
                    // RL3 read and write
                    dec_go = 1'b1;
                end
            end else if (in_bulk && bulk_ok) begin
                // RL19 bulk is read-only
                dec_exc  = is_write ? `MPM_EXC_VALUE : `MPM_EXC_NONE;
                dec_pres = !is_write;
            end else begin
                dec_exc = `MPM_EXC_ADDR;
            end
        // RL5 no points here
        end else begin
            dec_exc = `MPM_EXC_ADDR;
        end
    end

    // ****************************************************************
    // Transaction sequencer
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q     <= ST_IDLE;
            req_ready   <= 1'b1;
            lat_unit_q  <= 8'h00;
            lat_func_q  <= 8'h00;
            lat_addr_q  <= 16'h0000;
            lat_wdata_q <= 16'h0000;
            bulk_idx_q  <= 4'h0;
            bulk_k_q    <= 16'h0000;
            rsp_valid   <= 1'b0;
            rsp_data    <= 16'h0000;
            rsp_exc     <= `MPM_EXC_NONE;
            ir_req      <= 1'b0;
            ir_we       <= 1'b0;
            ir_fixed    <= 1'b0;
            ir_addr     <= 16'h0000;
            ir_wdata    <= 16'h0000;
        end else begin
            ir_req    <= 1'b0;
            rsp_valid <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    if (req_valid) begin
                        req_ready   <= 1'b0;
                        lat_unit_q  <= req_unit;
                        lat_func_q  <= req_func;
                        lat_addr_q  <= req_addr;
                        lat_wdata_q <= req_wdata;
                        rsp_exc     <= `MPM_EXC_NONE;
                        rsp_data    <= 16'h0000;
                        state_q     <= ST_DECODE;
                    end
                end
                ST_DECODE: begin
                    rsp_exc    <= dec_exc;
                    bulk_idx_q <= bulk_reg[3:0];
                    bulk_k_q   <= bulk_k;
                    ir_wdata   <= lat_wdata_q;
                    if (dec_go) begin
                        ir_req   <= 1'b1;
                        ir_we    <= is_write;
                        // RL16 RL17 RL18 model layout kept
                        ir_fixed <= (lat_unit_q == `MPM_UNIT_FIXED);
                        // RL1 point redirection
                        ir_addr  <= (lat_unit_q == `MPM_UNIT_FIXED) ? lat_addr_q - `MPM_FIXED_BASE : tgt;
                        state_q  <= ST_ACCESS;
                    end else if (dec_pres) begin
                        // RL14 presence lookup first
                        ir_req   <= 1'b1;
                        ir_we    <= 1'b0;
                        ir_fixed <= 1'b0;
                        ir_addr  <= bulk_presence_pointer_q[bulk_reg[3:0]] + bulk_k;
                        state_q  <= ST_PRES;
                    end else begin
                        state_q <= ST_RESP;
                    end
                end
                ST_PRES: begin
                    if (ir_ack) begin
                        if (ir_rdata == 16'h0000) begin
                            rsp_exc <= `MPM_EXC_FAIL;
                            state_q <= ST_RESP;
                        end else begin
                            // RL20 instance k of array
                            ir_req  <= 1'b1;
                            ir_addr <= bulk_base_pointer_q[bulk_idx_q] + bulk_k_q;
                            state_q <= ST_ACCESS;
                        end
                    end
                end
                ST_ACCESS: begin
                    if (ir_ack) begin
                        rsp_data <= ir_we ? lat_wdata_q : ir_rdata;
                        state_q  <= ST_RESP;
                    end
                end
                ST_RESP: begin
                    rsp_valid <= 1'b1;
                    req_ready <= 1'b1;
                    state_q   <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_holding_only: assert property (@(posedge aclk) disable iff (!aresetn) // RL8
        (state_q == ST_DECODE && !func_ok) |=> (rsp_exc == `MPM_EXC_FUNC && !ir_req) ##1 rsp_valid)
        else $error("non-holding function not refused");
    a_unit_none: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
        (state_q == ST_DECODE && func_ok && lat_unit_q != `MPM_UNIT_FIXED && lat_unit_q != `MPM_UNIT_CONFIG)
        |=> rsp_exc == `MPM_EXC_ADDR && state_q == ST_RESP)
        else $error("unit without points answered");
    a_fixed_base: assert property (@(posedge aclk) disable iff (!aresetn) // RL6
        (state_q == ST_DECODE && func_ok && lat_unit_q == `MPM_UNIT_FIXED && in_fixed)
        |=> ir_req && ir_fixed && ir_addr == lat_addr_q - `MPM_FIXED_BASE)
        else $error("fixed space offset wrong");
    a_map_target: assert property (@(posedge aclk) disable iff (!aresetn) // RL12
        (state_q == ST_DECODE && lat_unit_q == `MPM_UNIT_CONFIG && lat_func_q == `MPM_FC_READ_HOLD && in_map)
        |=> ir_req && !ir_we && !ir_fixed && ir_addr == $past(tgt))
        else $error("point read not redirected");
    a_ro_refused: assert property (@(posedge aclk) disable iff (!aresetn) // RL11
        (state_q == ST_DECODE && lat_unit_q == `MPM_UNIT_CONFIG && is_write && in_map
         && map_mode_q[map_idx] == `MPM_MODE_RO) |=> !ir_req [*2] ##0 rsp_exc == `MPM_EXC_VALUE)
        else $error("read-only point written");
    a_lock_guard: assert property (@(posedge aclk) disable iff (!aresetn) // RL4
        (state_q == ST_DECODE && lat_unit_q == `MPM_UNIT_CONFIG && is_write && in_map
         && lock_q && tgt_safe) |=> rsp_exc == `MPM_EXC_VALUE && state_q == ST_RESP)
        else $error("locked safety write passed");
    a_bulk_ro: assert property (@(posedge aclk) disable iff (!aresetn) // RL10
        (state_q == ST_DECODE && func_ok && lat_unit_q == `MPM_UNIT_CONFIG && is_write && in_bulk)
        |=> !ir_req && state_q == ST_RESP)
        else $error("bulk window written");
    a_bulk_absent: assert property (@(posedge aclk) disable iff (!aresetn) // RL14
        (state_q == ST_PRES && ir_ack && ir_rdata == 16'h0000)
        |=> rsp_exc == `MPM_EXC_FAIL ##1 rsp_valid && rsp_exc == `MPM_EXC_FAIL)
        else $error("absent instance not refused");
    a_bulk_data: assert property (@(posedge aclk) disable iff (!aresetn) // RL20
        (state_q == ST_PRES && ir_ack && ir_rdata != 16'h0000)
        |=> ir_req && ir_addr == bulk_base_pointer_q[bulk_idx_q] + bulk_k_q)
        else $error("bulk instance address wrong");

endmodule // modbus_point_mapper
`default_nettype wire

// File: hw/modbus_point_mapper_params.svh
`ifndef MODBUS_POINT_MAPPER_PARAMS_SVH
`define MODBUS_POINT_MAPPER_PARAMS_SVH

// ****************************************************************
// Modbus address spaces
// ****************************************************************
`define MPM_UNIT_FIXED      8'h01
`define MPM_UNIT_CONFIG     8'h02
`define MPM_FIXED_BASE      16'h9c40
`define MPM_REGION0_END     16'h03ff
`define MPM_BULK_START      16'h0400
`define MPM_BULK_SPAN       16'h0780
`define MPM_BULK_END        16'h7bff

// ****************************************************************
// Function and exception codes
// ****************************************************************
`define MPM_FC_READ_HOLD    8'h03
`define MPM_FC_WRITE_HOLD   8'h06
`define MPM_EXC_NONE        8'h00
`define MPM_EXC_FUNC        8'h01
`define MPM_EXC_ADDR        8'h02
`define MPM_EXC_VALUE       8'h03
`define MPM_EXC_FAIL        8'h04

// ****************************************************************
// Point-map entry fields and reset values
// ****************************************************************
`define MPM_MODE_RO         1'b0
`define MPM_MODE_RW         1'b1
`define MPM_MAP_MODE_BIT    16
`define MPM_SAFE_LO_RST     16'h0000
`define MPM_SAFE_HI_RST     16'hffff

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define MPM_OFS_MAP         12'h000
`define MPM_OFS_BULK_BASE   12'h400
`define MPM_OFS_BULK_PRES   12'h440
`define MPM_OFS_SAFE_LO     12'h480
`define MPM_OFS_SAFE_HI     12'h484
`define MPM_OFS_STATUS      12'h488
`define MPM_RESP_OKAY       2'b00
`define MPM_RESP_SLVERR     2'b10

`endif

// File: hw/point_mapper_pkg.sv
package point_mapper_pkg;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_DECODE = 5'b00010,
        ST_PRES   = 5'b00100,
        ST_ACCESS = 5'b01000,
        ST_RESP   = 5'b10000
    } mapper_state_e;

endpackage

// File: bench/fabric_model.sv
`timescale 1ns/1ps
`default_nettype none
module fabric_model (
    // Clock and fabric
    input  wire logic        aclk,
    input  wire logic        ir_req,
    input  wire logic        ir_we,
    input  wire logic        ir_fixed,
    input  wire logic [15:0] ir_addr,
    input  wire logic [15:0] ir_wdata,
    input  wire logic [1:0]  lag,
    output logic             ir_ack,
    output logic [15:0]      ir_rdata
);
    logic [15:0] mem [256];
    logic [15:0] a_q, d_q;
    logic        we_q, fx_q, busy_q;
    logic [1:0]  cnt_q;
    initial begin
        for (int i = 0; i < 255; i++) mem[i] = {8'hc0, i[7:0]};
        mem[255] = 16'h0000;
        busy_q = 1'b0;
        ir_ack = 1'b0;
        ir_rdata = 16'h0000;
    end
    always @(posedge aclk) begin
        ir_ack <= 1'b0;
        // Stale data never looks valid
        ir_rdata <= ~ir_rdata;
        if (ir_req) {a_q, d_q, we_q, fx_q, cnt_q, busy_q} <= {ir_addr, ir_wdata, ir_we, ir_fixed, lag, 1'b1};
        else if (busy_q && cnt_q != 2'd0) cnt_q <= cnt_q - 2'd1;
        else if (busy_q) begin
            busy_q <= 1'b0;
            ir_ack <= 1'b1;
            ir_rdata <= mem[a_q[7:0]] ^ {fx_q, 15'h0000};
            if (we_q) mem[a_q[7:0]] <= d_q;
        end
    end
endmodule // fabric_model
`default_nettype wire

// File: bench/modbus_point_mapper_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module modbus_point_mapper_tb_top;
    typedef struct packed {
        logic [7:0]  unit;
        logic [7:0]  func;
        logic [15:0] addr;
        logic [15:0] wd;
        logic [1:0]  lag;
        logic [15:0] ed;
        logic [7:0]  ex;
    } row_s;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        req_valid, req_ready, rsp_valid, factory_lock, ir_req, ir_we, ir_fixed, ir_ack;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp, lag;
    logic [7:0]  req_unit, req_func, rsp_exc;
    logic [15:0] req_addr, req_wdata, rsp_data, ir_addr, ir_wdata, ir_rdata;
    int          n_fail, n_compared, cyc;
    row_s        rows [19];
    modbus_point_mapper dut (.s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .s_axi_wstrb(4'hf), .*);
    fabric_model fab (.*);
    // ****
    // Tasks
    // ****
    task automatic end_sim();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        cmp({s_axi_bresp, 32'h0}, {er, 32'h0});
    endtask
    task automatic axi_rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        cmp({s_axi_rresp, s_axi_rdata}, {er, d});
    endtask
    task automatic mb(input row_s r);
        @(posedge aclk);
        {req_unit, req_func, req_addr, req_wdata, lag, req_valid} <= {r.unit, r.func, r.addr, r.wd, r.lag, 1'b1};
        do @(posedge aclk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        do @(posedge aclk); while (rsp_valid !== 1'b1);
        cmp({rsp_exc, rsp_data}, {r.ex, r.ed});
    endtask
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            end_sim();
        end
    end
    // ****
    // Main sequence
    // ****
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, req_valid} = 7'h00;
        {factory_lock, s_axi_awaddr, s_axi_araddr, s_axi_wdata, lag, req_unit, req_func, req_addr, req_wdata} = '0;
        {n_fail, n_compared, cyc} = '0;
        rows = '{'{2, 3, 16'h0005, 0, 0, 16'hc012, 0}, '{2, 6, 16'h0005, 16'h1111, 3, 16'h1111, 0},
            '{2, 3, 16'h0005, 0, 1, 16'h1111, 0}, '{2, 6, 16'h0006, 16'h5555, 0, 0, 3},
            '{2, 3, 16'h0006, 0, 2, 16'hc013, 0}, '{1, 3, 16'h9c45, 0, 0, 16'h4005, 0},
            '{0, 3, 16'h0005, 0, 0, 0, 2}, '{3, 3, 16'h0005, 0, 0, 0, 2}, '{255, 3, 16'h0005, 0, 0, 0, 2},
            '{2, 4, 16'h0005, 0, 0, 0, 1}, '{1, 3, 16'h9c3f, 0, 0, 0, 2}, '{2, 3, 16'h0100, 0, 0, 0, 2},
            '{2, 3, 16'h0400, 0, 1, 16'hc020, 0}, '{2, 3, 16'h0401, 0, 0, 0, 4},
            '{2, 6, 16'h0400, 16'h7, 0, 0, 3}, '{2, 3, 16'h0b80, 0, 0, 16'hc000, 0},
            '{2, 3, 16'h7bff, 0, 3, 16'hc07f, 0}, '{2, 3, 16'h7c00, 0, 0, 0, 2},
            '{2, 6, 16'h0007, 16'h2222, 0, 16'h2222, 0}};
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(12'h484, 32'h0000ffff, 2'b00);
        axi_rd(12'h014, 32'h0, 2'b00);
        axi_rd(12'h48c, 32'h0, 2'b10);
        axi_wr(12'h488, 32'h0, 2'b10);
        axi_wr(12'h014, 32'h00010012, 2'b00);
        axi_wr(12'h018, 32'h00000013, 2'b00);
        axi_wr(12'h01c, 32'h00010030, 2'b00);
        axi_wr(12'h400, 32'h00000020, 2'b00);
        axi_wr(12'h440, 32'h000000fe, 2'b00);
        axi_wr(12'h480, 32'h00000030, 2'b00);
        axi_wr(12'h484, 32'h00000030, 2'b00);
        $display("test config done");
        foreach (rows[i]) mb(rows[i]);
        $display("test table done");
        factory_lock <= 1'b1;
        repeat (4) @(posedge aclk);
        mb('{2, 6, 16'h0007, 16'h3333, 0, 0, 3});
        mb('{2, 6, 16'h0005, 16'h4444, 0, 16'h4444, 0});
        mb('{2, 3, 16'h0007, 0, 0, 16'h2222, 0});
        axi_rd(12'h488, 32'h00000001, 2'b00);
        $display("test lock done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(12'h014, 32'h0, 2'b00);
        mb('{2, 6, 16'h0005, 16'h5, 0, 0, 3});
        $display("test reset done");
        end_sim();
    end
endmodule // modbus_point_mapper_tb_top
`default_nettype wire
